// ---- core/idc_consts.svh ----
// Constants of the dual edge input capture block: register offsets,
// field positions and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef IDC_CONSTS_SVH
`define IDC_CONSTS_SVH

// ==========================================================
// Register map, byte offsets on the Avalon slave.
`define IDC_ADDR_W          4
`define IDC_DATA_W          32
`define IDC_OFS_CONTROL     4'h0
`define IDC_OFS_STATUS      4'h4
`define IDC_OFS_PAIR_COUNT  4'h8

// ==========================================================
// Control register fields.
`define IDC_CTL_MODE_LSB    0
`define IDC_CTL_MODE_MSB    1
`define IDC_CTL_SYNC_BIT    2
`define IDC_CTL_RISE_FV_BIT 3
`define IDC_CTL_FALL_FV_BIT 4

// ==========================================================
// Status register fields.
`define IDC_STS_RISE_BIT    0
`define IDC_STS_FALL_BIT    1
`define IDC_STS_MODE_LSB    2
`define IDC_STS_MODE_MSB    3

// ==========================================================
// Reset values and counter width.
`define IDC_RST_SYNC        1'h0
`define IDC_RST_FV          1'h0
`define IDC_COUNT_W         16
`define IDC_COUNT_ONE       16'h0001
`define IDC_COUNT_ZERO      16'h0000

`endif

// ---- core/idc_pkg.sv ----
// Types shared by the dual edge input capture block.
// Assumes idc_consts.svh is available to the files that use it.
package idc_pkg;

   // ==========================================================
   // Edge alignment modes, in control register encoding order.
   typedef enum logic [1:0] {
      split_edge_mode,
      same_edge_mode,
      aligned_pipelined_mode,
      single_rate_mode
   } idc_mode_e;

   // ==========================================================
   // Software control of the capture tile.
   typedef struct packed {
      idc_mode_e mode;
      logic      force_sync_select;
      logic      rise_forced_value;
      logic      fall_forced_value;
   } idc_ctrl_s;

   // ==========================================================
   // One captured pair as handed to user logic.
   typedef struct packed {
      logic rise;
      logic fall;
   } idc_pair_s;

endpackage

// ---- core/idc_capture_cell.sv ----
// One capture flip-flop of the tile, on either clock edge.
// Assumes force_in, enable and data come from logic on the same clock.
`timescale 1ns/1ns
`include "idc_consts.svh"

module idc_capture_cell #(
   parameter bit   FALLING = 1'b0,
   parameter logic INIT    = 1'b0
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // Capture controls
   input  wire logic ce,
   input  wire logic d,
   // Force controls
   input  wire logic force_in,
   input  wire logic force_sync_select,
   input  wire logic forced_value,
   // Result
   output logic      q
);

   // ==========================================================
   // Force decoding.
   // The asynchronous path loads only constants, so the forced value
   // picks which of the two asynchronous inputs fires.
   logic async_clr;
   logic async_set;
   logic sync_force;

   assign async_clr  = force_in & ~force_sync_select & ~forced_value;
   assign async_set  = force_in & ~force_sync_select & forced_value;
   assign sync_force = force_in & force_sync_select;

   // ==========================================================
   // Storage.
   generate
      if (FALLING) begin : g_fall
         always_ff @(negedge clock or posedge async_clr
                     or posedge async_set) begin
            if (async_clr) begin
               q <= 1'b0;
            end else if (async_set) begin
               q <= 1'b1;
            end else if (srst) begin
               q <= INIT;
            end else if (sync_force) begin
               q <= forced_value;
            end else if (ce) begin
               q <= d;
            end
         end
      end else begin : g_rise
         always_ff @(posedge clock or posedge async_clr
                     or posedge async_set) begin
            if (async_clr) begin
               q <= 1'b0;
            end else if (async_set) begin
               q <= 1'b1;
            end else if (srst) begin
               q <= INIT;
            end else if (sync_force) begin
               q <= forced_value;
            end else if (ce) begin
               q <= d;
            end
         end
      end
   endgenerate

endmodule

// ---- core/idc_dual_edge_capture.sv ----
// Dual edge input capture tile with an Avalon-MM control slave.
// Assumes the data input arrives from the pad delay line already timed
// to this clock, and that enable and force come from user logic on it.
`timescale 1ns/1ns
`include "idc_consts.svh"

module idc_dual_edge_capture #(
   parameter logic RISE_OUT_INITIAL = 1'b0,
   parameter logic FALL_OUT_INITIAL = 1'b0
) (
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    srst,
   // Pad side
   input  wire logic                    delayed_pad_data_in,
   // User side controls
   input  wire logic                    capture_enable_in = 1'b1,
   input  wire logic                    force_in,
   // Avalon-MM slave
   input  wire logic [`IDC_ADDR_W-1:0] avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [`IDC_DATA_W-1:0] avs_writedata,
   output logic      [`IDC_DATA_W-1:0] avs_readdata,
   output logic                         avs_waitrequest,
   // Captured pair
   output logic                         rise_sample_out,
   output logic                         fall_sample_out
);

   // ==========================================================
   // Control register and bus handshake.
   idc_pkg::idc_ctrl_s          ctrl;
   idc_pkg::idc_pair_s          pair;
   logic [`IDC_COUNT_W-1:0]     pair_count;
   logic                        access;
   logic                        commit;

   // A request is answered one cycle after it is first seen: the
   // waitrequest flop drops for exactly one cycle and the write lands
   // on that edge.
   assign access = avs_read | avs_write;
   assign commit = access & ~avs_waitrequest;

   always_ff @(posedge clock) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(access & avs_waitrequest);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl.mode              <= idc_pkg::split_edge_mode;
         ctrl.force_sync_select <= `IDC_RST_SYNC;
         ctrl.rise_forced_value <= `IDC_RST_FV;
         ctrl.fall_forced_value <= `IDC_RST_FV;
      end else if (commit && avs_write
                   && avs_address == `IDC_OFS_CONTROL) begin
         ctrl.mode <= idc_pkg::idc_mode_e'(
            avs_writedata[`IDC_CTL_MODE_MSB:`IDC_CTL_MODE_LSB]);
         ctrl.force_sync_select <=
            avs_writedata[`IDC_CTL_SYNC_BIT];
         ctrl.rise_forced_value <=
            avs_writedata[`IDC_CTL_RISE_FV_BIT];
         ctrl.fall_forced_value <=
            avs_writedata[`IDC_CTL_FALL_FV_BIT];
      end
   end

   // ==========================================================
   // Read data; unmapped offsets read as zero.
   logic [`IDC_DATA_W-1:0] next_readdata;

   always_comb begin
      next_readdata = '0;
      unique case (avs_address)
         `IDC_OFS_CONTROL: begin
            next_readdata[`IDC_CTL_MODE_MSB:`IDC_CTL_MODE_LSB] = ctrl.mode;
            next_readdata[`IDC_CTL_SYNC_BIT] = ctrl.force_sync_select;
            next_readdata[`IDC_CTL_RISE_FV_BIT] = ctrl.rise_forced_value;
            next_readdata[`IDC_CTL_FALL_FV_BIT] = ctrl.fall_forced_value;
         end
         `IDC_OFS_STATUS: begin
            next_readdata[`IDC_STS_RISE_BIT] = pair.rise;
            next_readdata[`IDC_STS_FALL_BIT] = pair.fall;
            next_readdata[`IDC_STS_MODE_MSB:`IDC_STS_MODE_LSB] = ctrl.mode;
         end
         `IDC_OFS_PAIR_COUNT: begin
            next_readdata[`IDC_COUNT_W-1:0] = pair_count;
         end
         default: begin
            next_readdata = '0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         avs_readdata <= '0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   // ==========================================================
   // Capture path.
   // Enable and data feed both edges, so they must settle between the
   // rising and falling edges; the tile cannot repair a late change.
   logic fall_ce;
   logic rise_stage;
   logic rise_d;
   logic fall_cap;
   logic fall_retime;

   // Single-rate operation stops only the falling-edge register; the rising-edge ones stay active.
   assign fall_ce = capture_enable_in
                    & (ctrl.mode != idc_pkg::single_rate_mode);

   // The pipelined mode feeds the output from a one-clock stage.
   assign rise_d = (ctrl.mode == idc_pkg::aligned_pipelined_mode)
                   ? rise_stage : delayed_pad_data_in;

   idc_capture_cell #(
      .FALLING (1'b0),
      .INIT    (RISE_OUT_INITIAL)
   ) u_rise_stage (
      .clock             (clock),
      .srst              (srst),
      .ce                (capture_enable_in),
      .d                 (delayed_pad_data_in),
      .force_in          (force_in),
      .force_sync_select (ctrl.force_sync_select),
      .forced_value      (ctrl.rise_forced_value),
      .q                 (rise_stage)
   );

   idc_capture_cell #(
      .FALLING (1'b0),
      .INIT    (RISE_OUT_INITIAL)
   ) u_rise_out (
      .clock             (clock),
      .srst              (srst),
      .ce                (capture_enable_in),
      .d                 (rise_d),
      .force_in          (force_in),
      .force_sync_select (ctrl.force_sync_select),
      .forced_value      (ctrl.rise_forced_value),
      .q                 (rise_sample_out)
   );

   idc_capture_cell #(
      .FALLING (1'b1),
      .INIT    (FALL_OUT_INITIAL)
   ) u_fall_cap (
      .clock             (clock),
      .srst              (srst),
      .ce                (fall_ce),
      .d                 (delayed_pad_data_in),
      .force_in          (force_in),
      .force_sync_select (ctrl.force_sync_select),
      .forced_value      (ctrl.fall_forced_value),
      .q                 (fall_cap)
   );

   idc_capture_cell #(
      .FALLING (1'b0),
      .INIT    (FALL_OUT_INITIAL)
   ) u_fall_retime (
      .clock             (clock),
      .srst              (srst),
      .ce                (capture_enable_in),
      .d                 (fall_cap),
      .force_in          (force_in),
      .force_sync_select (ctrl.force_sync_select),
      .forced_value      (ctrl.fall_forced_value),
      .q                 (fall_retime)
   );

   // The split mode must change on the falling edge, which no single
   // rising flop can do, so the second output selects between two flops.
   assign fall_sample_out = (ctrl.mode == idc_pkg::split_edge_mode)
                            ? fall_cap : fall_retime;

   assign pair.rise = rise_sample_out;
   assign pair.fall = fall_sample_out;

   // ==========================================================
   // Count of enabled, unforced rising edges, for software monitoring.
   always_ff @(posedge clock) begin
      if (srst) begin
         pair_count <= `IDC_COUNT_ZERO;
      end else if (capture_enable_in && !force_in) begin
         pair_count <= pair_count + `IDC_COUNT_ONE;
      end
   end

endmodule

// ---- verification/idc_dual_edge_capture_assertions.sv ----
// Port-level checker for the dual edge capture tile.
// Assumes a bind from the bench top that hands on both parameters.
`timescale 1ns/1ns
`include "idc_consts.svh"
module idc_dual_edge_capture_assertions #(
   parameter logic RISE_OUT_INITIAL = 1'b0,
   parameter logic FALL_OUT_INITIAL = 1'b0
) (
   // Clock and reset
   input wire logic                   clock,
   input wire logic                   srst,
   // Capture side
   input wire logic                   capture_enable_in,
   input wire logic                   force_in,
   input wire logic                   rise_sample_out,
   input wire logic                   fall_sample_out,
   // Bus side
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [`IDC_DATA_W-1:0] avs_readdata,
   input wire logic                   avs_waitrequest
);
   wire logic bus_req = avs_read || avs_write;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // ==========================================================
   // Bus handshake.
   wait_answer_a: assert property (
      bus_req && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one cycle");
   wait_pulse_a: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   wait_cause_a: assert property (
      !avs_waitrequest |-> $past(bus_req))
      else $error("waitrequest dropped without a request");
   idle_wait_a: assert property (!bus_req |=> avs_waitrequest)
      else $error("waitrequest low while idle");
   read_stands_a: assert property (
      !$stable(avs_readdata) |-> $past(avs_read))
      else $error("read data changed without a read");
   // ==========================================================
   // Capture behaviour.
   rise_hold_a: assert property (
      !capture_enable_in && !force_in ##1 !force_in
      |-> $stable(rise_sample_out))
      else $error("first output moved while disabled");
   fall_hold_a: assert property (
      (!capture_enable_in && !force_in) [*2]
      |-> $stable(fall_sample_out))
      else $error("second output moved while disabled");
   force_hold_a: assert property (
      (force_in && !avs_write) [*4]
      |-> $stable(rise_sample_out) && $stable(fall_sample_out))
      else $error("outputs moved while forced");
   // The falling flop may already capture data on the falling edge that
   // follows release, so its reset value is judged one edge back.
   init_value_a: assert property (
      $fell(srst) && !force_in
      |-> rise_sample_out == RISE_OUT_INITIAL
          && $past(fall_sample_out) == FALL_OUT_INITIAL)
      else $error("outputs not at initial values after reset");
   cover property (!capture_enable_in [*2]);
   cover property (force_in [*4]);
   cover property (avs_read && !avs_waitrequest);
endmodule

// ---- verification/idc_user_logic.sv ----
// Model of the user logic beside the capture tile: it drives enable and
// force on request from the bench and keeps the last captured pair.
// Assumes requests change just after rising edges.
`timescale 1ns/1ns
module idc_user_logic (
   // Clock
   input wire logic           clock,
   // Requests from the bench
   input wire logic           enable_req,
   input wire logic           force_req,
   // Tile side
   output logic               capture_enable_in,
   output logic               force_in,
   input wire logic           rise_sample_out,
   input wire logic           fall_sample_out,
   output idc_pkg::idc_pair_s last_pair
);
   // A single force line, so set and reset are never asked for together.
   assign force_in = force_req;
   // Held from one rising edge to the next, so both edges see it steady.
   assign capture_enable_in = enable_req;
   always_ff @(posedge clock) begin
      last_pair <= '{rise: rise_sample_out, fall: fall_sample_out};
   end
endmodule

// ---- verification/tb_input_ddr_capture.sv ----
// Self-checking bench for the dual edge capture tile.
// Assumes the tile, its checker and the user logic model are compiled.
`timescale 1ns/1ns
`include "idc_consts.svh"
module tb_input_ddr_capture;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        din = 1'b0;
   logic        en_req = 1'b1;
   logic        frc_req = 1'b0;
   logic        cen;
   logic        frc;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic        wreq;
   logic        rise_o;
   logic        fall_o;
   int          err_count = 0;
   int          check_count = 0;
   idc_pkg::idc_pair_s pair;
   always #50 clock = ~clock;
   idc_dual_edge_capture #(.RISE_OUT_INITIAL (1'b1),
      .FALL_OUT_INITIAL (1'b0)) dut (.clock (clock), .srst (srst),
      .delayed_pad_data_in (din), .capture_enable_in (cen),
      .force_in (frc), .avs_address (addr), .avs_read (rd),
      .avs_write (wr), .avs_writedata (wdata), .avs_readdata (rdata),
      .avs_waitrequest (wreq), .rise_sample_out (rise_o),
      .fall_sample_out (fall_o));
   idc_user_logic user (.clock (clock), .enable_req (en_req),
      .force_req (frc_req), .capture_enable_in (cen), .force_in (frc),
      .rise_sample_out (rise_o), .fall_sample_out (fall_o),
      .last_pair (pair));
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clock); while (wreq !== 1'b0);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic put(input logic d, input logic e, input logic f);
      @(posedge clock);
      din <= d;
      en_req <= e;
      frc_req <= f;
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_reset;
      repeat (7) @(posedge clock);
      #10;
      chk(rise_o, 1'b1);
      chk(fall_o, 1'b0);
      @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, `IDC_OFS_CONTROL, 32'h0);
      chk(rv, 32'h0);
      bus(1'b0, 4'hC, 32'h0);
      chk(rv, 32'h0);
      $display("test_reset done");
   endtask
   task automatic test_modes;
      logic [7:0] b;
      b = 8'hD2;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, `IDC_OFS_CONTROL, m);
         bus(1'b0, `IDC_OFS_STATUS, 32'h0);
         chk(rv[3:2], m);
         for (int k = 0; k < 8; k++) begin
            put(b[k], 1'b1, 1'b0);
            #60;
            if (k > 1) begin
               chk(rise_o, (m == 2) ? b[k-2] : b[k-1]);
               if (m != 3)
                  chk(fall_o, (m == 0) ? b[k] : b[k-1]);
            end
         end
      end
      $display("test_modes done");
   endtask
   task automatic test_enable;
      logic [31:0] cnt;
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, `IDC_OFS_CONTROL, m);
         repeat (3) put(1'b1, 1'b1, 1'b0);
         repeat (3) put(1'b0, 1'b0, 1'b0);
         #60;
         chk(rise_o, 1'b1);
         chk(fall_o, 1'b1);
         // Enable stays low across these reads, so nothing may move.
         bus(1'b0, `IDC_OFS_STATUS, 32'h0);
         chk(rv[1:0], 2'b11);
         chk(pair, 2'b11);
         bus(1'b0, `IDC_OFS_PAIR_COUNT, 32'h0);
         cnt = rv;
         bus(1'b0, `IDC_OFS_PAIR_COUNT, 32'h0);
         chk(rv, cnt);
         repeat (3) put(1'b0, 1'b1, 1'b0);
         #60;
         chk(rise_o, 1'b0);
         chk(fall_o, 1'b0);
      end
      $display("test_enable done");
   endtask
   task automatic test_force;
      logic fv;
      for (int i = 0; i < 4; i++) begin
         fv = i[0];
         bus(1'b1, `IDC_OFS_CONTROL, {27'h0, fv, fv, i[1], 2'b00});
         repeat (2) put(~fv, 1'b1, 1'b0);
         put(~fv, 1'b1, 1'b1);
         #10;
         chk(rise_o, i[1] ? !fv : fv);
         if (!i[1]) chk(fall_o, fv);
         put(~fv, 1'b1, 1'b1);
         #10;
         chk(rise_o, fv);
         #50;
         chk(fall_o, fv);
         // A longer hold: the outputs must not follow the data meanwhile.
         repeat (3) put(~fv, 1'b1, 1'b1);
         #10;
         chk(rise_o, fv);
         chk(fall_o, fv);
         put(~fv, 1'b1, 1'b0);
      end
      $display("test_force done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      summarize();
   end
   initial begin
      test_reset();
      test_modes();
      test_enable();
      test_force();
      summarize();
   end
endmodule
bind idc_dual_edge_capture idc_dual_edge_capture_assertions #(
   .RISE_OUT_INITIAL (RISE_OUT_INITIAL),
   .FALL_OUT_INITIAL (FALL_OUT_INITIAL)) chk_i (.clock (clock),
   .srst (srst), .capture_enable_in (capture_enable_in),
   .force_in (force_in), .rise_sample_out (rise_sample_out),
   .fall_sample_out (fall_sample_out), .avs_read (avs_read),
   .avs_write (avs_write), .avs_readdata (avs_readdata),
   .avs_waitrequest (avs_waitrequest));
